// *** hdl/gating_pkg.sv ***
package gating_pkg;

    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 32;
    localparam int PERIOD_W = 16;
    localparam int SYNC_W   = 10;

    // register offsets (byte addresses)
    localparam logic [ADDR_W-1:0] CTRL_OFS   = 8'h00;
    localparam logic [ADDR_W-1:0] GUARD_OFS  = 8'h04;
    localparam logic [ADDR_W-1:0] ON_OFS     = 8'h08;
    localparam logic [ADDR_W-1:0] REST_OFS   = 8'h0C;
    localparam logic [ADDR_W-1:0] STATUS_OFS = 8'h10;

    // control and status field positions
    localparam int CTRL_SRC_BIT   = 0;
    localparam int ST_SW_LSB      = 0;
    localparam int ST_BUSY_LSB    = 4;
    localparam int ST_MODE_LSB    = 8;
    localparam int ST_SUPPLY_BIT  = 12;
    localparam int ST_WIN_BIT     = 13;

    // reset values
    localparam logic                CTRL_SRC_RST = 1'b0;
    localparam logic [PERIOD_W-1:0] GUARD_RST    = 16'h0100;
    localparam logic [PERIOD_W-1:0] ON_RST       = 16'h0100;
    localparam logic [PERIOD_W-1:0] REST_RST     = 16'h0400;

    typedef enum logic [1:0] {
        MODE_ENERGY = 2'b00,
        MODE_EVENT1 = 2'b01,
        MODE_EVENT2 = 2'b11,
        MODE_TIMER  = 2'b10
    } gate_mode_e;

    typedef struct packed {
        logic              psel;
        logic              penable;
        logic              pwrite;
        logic [ADDR_W-1:0] paddr;
        logic [DATA_W-1:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic              pready;
        logic              pslverr;
        logic [DATA_W-1:0] prdata;
    } apb_rsp_s;

    // pin-side detection flags and straps, all levels
    typedef struct packed {
        logic upper_limit_detect;
        logic lower_limit_detect;
        logic supply_detect;
        logic supply_undetect;
        logic battery_detect;
        logic battery_undetect;
        logic load_request;
        logic on_strap_cap;
        logic rest_strap_cap;
        logic rest_strap_gnd;
    } det_s;

    typedef struct packed {
        logic storage_to_load_a_switch;
        logic storage_to_load_b_switch;
        logic battery_to_load_a_switch;
        logic battery_to_load_b_switch;
    } sw_s;

    typedef struct packed {
        logic guard_busy_flag;
        logic on_busy_flag;
        logic rest_busy_flag;
    } busy_s;

    typedef struct packed {
        logic [SYNC_W-1:0] meta;
        logic [SYNC_W-1:0] stable;
    } sync_state_s;

    typedef struct packed {
        logic                busy;
        logic                done;
        logic [PERIOD_W-1:0] count;
    } timer_state_s;

    typedef struct packed {
        apb_rsp_s            rsp;
        logic                src_battery;
        logic [PERIOD_W-1:0] guard_period;
        logic [PERIOD_W-1:0] on_period;
        logic [PERIOD_W-1:0] rest_period;
        gate_mode_e          mode;
        logic                supply_ok;
        logic                stor_win;
        logic                bat_win;
        logic [5:0]          prev;
        sw_s                 sw;
    } gate_state_s;

endpackage : gating_pkg

// *** hdl/flag_sync.sv ***
`timescale 1ns/100ps
module flag_sync
    import gating_pkg::*;
(
    // clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // flags
    input  gating_pkg::det_s  raw,
    output gating_pkg::det_s  synced
);
    sync_state_s s_q;
    sync_state_s s_d;

    always_comb begin
        s_d.meta   = raw;
        s_d.stable = s_q.meta;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign synced = s_q.stable;

endmodule : flag_sync

// *** hdl/period_timer.sv ***
`timescale 1ns/100ps
module period_timer
    import gating_pkg::*;
(
    // clock and reset
    input  wire logic                          pclk,
    input  wire logic                          presetn,
    // control
    input  wire logic                          start,
    input  wire logic                          clear,
    input  wire logic [gating_pkg::PERIOD_W-1:0] period,
    // status
    output logic                               busy,
    output logic                               done
);
    timer_state_s        s_q;
    timer_state_s        s_d;
    logic [PERIOD_W:0]   count_inc;

    assign count_inc = {1'b0, s_q.count} + {{PERIOD_W{1'b0}}, 1'b1};

    always_comb begin
        s_d      = s_q;
        s_d.done = 1'b0;
        if (clear) begin
            s_d.busy  = 1'b0;
            s_d.count = '0;
        end else if (s_q.busy) begin
            // period of zero behaves as one cycle
            if (count_inc >= {1'b0, period}) begin
                s_d.busy  = 1'b0;
                s_d.count = '0;
                s_d.done  = 1'b1;
            end else begin
                s_d.count = count_inc[PERIOD_W-1:0];
            end
        end else if (start) begin
            s_d.busy  = 1'b1;
            s_d.count = '0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy = s_q.busy;
    assign done = s_q.done;

endmodule : period_timer

// *** hdl/load_power_gating_control.sv ***
`timescale 1ns/100ps
module load_power_gating_control
    import gating_pkg::*;
(
    // clock and reset
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    // register bus
    input  gating_pkg::apb_req_s         apb_req,
    output gating_pkg::apb_rsp_s         apb_rsp,
    // comparator flags, request and straps from pins
    input  gating_pkg::det_s             det_raw,
    // load switches
    output gating_pkg::sw_s              sw,
    // timer flags
    output gating_pkg::busy_s            busy,
    // latched operating mode
    output gating_pkg::gate_mode_e       mode
);
    import gating_pkg::*;

    gate_state_s s_q;
    gate_state_s s_d;
    det_s        det;

    logic [5:0]  now_lvl;
    logic [5:0]  rise;
    logic        src;
    logic        win;
    logic        start_evt;
    logic        clear_evt;
    logic        supply_lost;
    logic        guard_start;
    logic        on_start;
    logic        rest_start;
    logic        guard_clr;
    logic        on_clr;
    logic        rest_clr;
    logic        guard_busy;
    logic        on_busy;
    logic        rest_busy;
    logic        guard_done;
    logic        on_done;
    logic        rest_done;
    logic        cycle_idle;
    logic        a_on;
    logic        b_on;
    logic        access;
    logic        mapped;

    function automatic logic is_mapped(input logic [ADDR_W-1:0] addr);
        is_mapped = (addr == CTRL_OFS) || (addr == GUARD_OFS) || (addr == ON_OFS)
                 || (addr == REST_OFS) || (addr == STATUS_OFS);
    endfunction : is_mapped

    function automatic gate_mode_e decode_mode(input det_s d);
        // unlisted strap combinations fall back to energy driven
        if (!d.on_strap_cap && !d.rest_strap_cap && d.rest_strap_gnd) begin
            decode_mode = MODE_EVENT1;
        end else if (d.on_strap_cap && !d.rest_strap_cap && !d.rest_strap_gnd) begin
            decode_mode = MODE_EVENT2;
        end else if (d.on_strap_cap && d.rest_strap_cap) begin
            decode_mode = MODE_TIMER;
        end else begin
            decode_mode = MODE_ENERGY;
        end
    endfunction : decode_mode

    function automatic logic [DATA_W-1:0] read_value(input logic [ADDR_W-1:0] addr,
                                                     input gate_state_s st,
                                                     input busy_s bz);
        logic [DATA_W-1:0] v;
        v = '0;
        case (addr)
            CTRL_OFS: begin
                v[CTRL_SRC_BIT] = st.src_battery;
            end
            GUARD_OFS: begin
                v[PERIOD_W-1:0] = st.guard_period;
            end
            ON_OFS: begin
                v[PERIOD_W-1:0] = st.on_period;
            end
            REST_OFS: begin
                v[PERIOD_W-1:0] = st.rest_period;
            end
            STATUS_OFS: begin
                v[ST_SW_LSB +: 4]   = st.sw;
                v[ST_BUSY_LSB +: 3] = bz;
                v[ST_MODE_LSB +: 2] = st.mode;
                v[ST_SUPPLY_BIT]    = st.supply_ok;
                v[ST_WIN_BIT]       = st.src_battery ? st.bat_win : st.stor_win;
            end
            default: begin
                v = '0;
            end
        endcase
        read_value = v;
    endfunction : read_value

    // every pin flag passes two flip-flops first
    flag_sync u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .raw     (det_raw),
        .synced  (det)
    );

    // edge events from the synchronised levels
    assign now_lvl = {det.upper_limit_detect, det.lower_limit_detect, det.supply_detect,
                      det.supply_undetect, det.battery_detect, det.battery_undetect};
    assign rise    = now_lvl & ~s_q.prev;

    // supply comparators carry the hysteresis; detect sets, undetect clears
    assign supply_lost = rise[2] | ~s_q.supply_ok;

    assign src       = s_q.src_battery;
    assign win       = src ? s_q.bat_win : s_q.stor_win;
    assign start_evt = src ? rise[1] : rise[5];
    assign clear_evt = src ? rise[0] : rise[4];

    assign cycle_idle = ~guard_busy & ~on_busy & ~rest_busy;

    // timer start and clear steering per mode
    always_comb begin
        guard_start = 1'b0;
        on_start    = 1'b0;
        rest_start  = 1'b0;
        guard_clr   = supply_lost;
        on_clr      = supply_lost;
        rest_clr    = supply_lost;
        case (s_q.mode)
            MODE_EVENT1: begin
                guard_start = start_evt;
            end
            MODE_EVENT2: begin
                guard_start = start_evt;
                // request ignored while the guard timer counts
                on_start    = det.load_request & ~guard_busy & ~on_busy & win;
                guard_clr   = supply_lost | clear_evt;
                on_clr      = supply_lost | clear_evt;
            end
            MODE_TIMER: begin
                // first detect starts a cycle, then rest completion restarts it while the window is open
                guard_start = (start_evt & cycle_idle) | (rest_done & win);
                on_start    = (start_evt & cycle_idle) | (rest_done & win);
                rest_start  = on_done;
                guard_clr   = supply_lost | clear_evt;
                on_clr      = supply_lost | clear_evt;
                rest_clr    = supply_lost | (src & clear_evt);
            end
            default: begin
                guard_start = 1'b0;
            end
        endcase
    end

    // three independent timers, each with its own period
    period_timer u_guard (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (guard_start),
        .clear   (guard_clr),
        .period  (s_q.guard_period),
        .busy    (guard_busy),
        .done    (guard_done)
    );

    period_timer u_on (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (on_start),
        .clear   (on_clr),
        .period  (s_q.on_period),
        .busy    (on_busy),
        .done    (on_done)
    );

    period_timer u_rest (
        .pclk    (pclk),
        .presetn (presetn),
        .start   (rest_start),
        .clear   (rest_clr),
        .period  (s_q.rest_period),
        .busy    (rest_busy),
        .done    (rest_done)
    );

    // switch decision for the two loads
    always_comb begin
        a_on = 1'b0;
        b_on = 1'b0;
        case (s_q.mode)
            MODE_ENERGY: begin
                a_on = win;
                b_on = win;
            end
            MODE_EVENT1: begin
                a_on = win;
                b_on = win & det.load_request & ~guard_busy;
            end
            MODE_EVENT2: begin
                a_on = win;
                b_on = win & on_busy;
            end
            MODE_TIMER: begin
                a_on = on_busy & ~rest_busy;
                b_on = on_busy & ~guard_busy & ~rest_busy;
            end
            default: begin
                a_on = 1'b0;
            end
        endcase
    end

    assign access = apb_req.psel & apb_req.penable;
    assign mapped = is_mapped(apb_req.paddr);

    always_comb begin
        s_d            = s_q;
        s_d.rsp.pready = 1'b0;
        s_d.prev       = now_lvl;

        // supply detect latches the strap mode
        if (rise[3]) begin
            s_d.supply_ok = 1'b1;
            if (!s_q.supply_ok) begin
                s_d.mode = decode_mode(det);
            end
        end
        if (rise[2]) begin
            s_d.supply_ok = 1'b0;
        end

        // energy windows, set on the upper event and cleared on the lower
        if (rise[5]) begin
            s_d.stor_win = 1'b1;
        end
        if (rise[4]) begin
            s_d.stor_win = 1'b0;
        end
        if (rise[1]) begin
            s_d.bat_win = 1'b1;
        end
        if (rise[0]) begin
            s_d.bat_win = 1'b0;
        end
        if (supply_lost) begin
            s_d.stor_win = 1'b0;
            s_d.bat_win  = 1'b0;
        end

        s_d.sw.storage_to_load_a_switch = s_q.supply_ok & ~src & a_on;
        s_d.sw.storage_to_load_b_switch = s_q.supply_ok & ~src & b_on;
        s_d.sw.battery_to_load_a_switch = s_q.supply_ok & src & a_on;
        s_d.sw.battery_to_load_b_switch = s_q.supply_ok & src & b_on;

        // one wait state, then the answer stands for one cycle
        if (access && !s_q.rsp.pready) begin
            s_d.rsp.pready  = 1'b1;
            s_d.rsp.pslverr = ~mapped;
            s_d.rsp.prdata  = apb_req.pwrite ? '0
                            : read_value(apb_req.paddr, s_q, busy);
        end
        if (access && s_q.rsp.pready && apb_req.pwrite && mapped) begin
            case (apb_req.paddr)
                CTRL_OFS: begin
                    s_d.src_battery = apb_req.pwdata[CTRL_SRC_BIT];
                end
                GUARD_OFS: begin
                    s_d.guard_period = apb_req.pwdata[PERIOD_W-1:0];
                end
                ON_OFS: begin
                    s_d.on_period = apb_req.pwdata[PERIOD_W-1:0];
                end
                REST_OFS: begin
                    s_d.rest_period = apb_req.pwdata[PERIOD_W-1:0];
                end
                default: begin
                    s_d.src_battery = s_q.src_battery;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_q              <= '0;
            s_q.src_battery  <= CTRL_SRC_RST;
            s_q.guard_period <= GUARD_RST;
            s_q.on_period    <= ON_RST;
            s_q.rest_period  <= REST_RST;
            s_q.mode         <= MODE_ENERGY;
        end else begin
            s_q <= s_d;
        end
    end

    assign apb_rsp = s_q.rsp;
    assign sw      = s_q.sw;
    assign mode    = s_q.mode;
    assign busy    = '{guard_busy_flag: guard_busy, on_busy_flag: on_busy,
                       rest_busy_flag: rest_busy};

endmodule : load_power_gating_control

// *** bench/gating_chk.sv ***
`timescale 1ns/100ps
module gating_chk
    import gating_pkg::*;
(
    // clock and reset
    input wire logic              pclk,
    input wire logic              presetn,
    // bus and pins
    input gating_pkg::apb_req_s   apb_req,
    input gating_pkg::apb_rsp_s   apb_rsp,
    input gating_pkg::det_s       det_raw,
    // outputs
    input gating_pkg::sw_s        sw,
    input gating_pkg::busy_s      busy,
    input gating_pkg::gate_mode_e mode
);
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    logic a_on;
    logic b_on;
    assign a_on = sw.storage_to_load_a_switch | sw.battery_to_load_a_switch;
    assign b_on = sw.storage_to_load_b_switch | sw.battery_to_load_b_switch;

    AST_APB_ANSWER: assert property ($rose(apb_req.penable) && apb_req.psel |=> apb_rsp.pready)
        else $error("pready not one cycle after access");
    AST_PREADY_PULSE: assert property (apb_rsp.pready |=> !apb_rsp.pready)
        else $error("pready longer than one cycle");
    AST_UNMAPPED: assert property (apb_rsp.pready && apb_req.paddr > STATUS_OFS |-> apb_rsp.pslverr)
        else $error("unmapped access without error");
    AST_MODE_HELD: assert property ($changed(mode) |-> $past(busy) == 3'b000)
        else $error("mode changed while a timer ran");
    AST_ENERGY_PAIR: assert property (mode == MODE_ENERGY |-> sw[3] == sw[2] && sw[1] == sw[0])
        else $error("energy mode outputs differ");
    AST_EV1_GUARD: assert property (mode == MODE_EVENT1 && busy.guard_busy_flag
        && $past(busy.guard_busy_flag) |-> !b_on) else $error("output b closed during guard");
    AST_EV2_START: assert property (mode == MODE_EVENT2 && $rose(busy.on_busy_flag) |->
        $past(det_raw.load_request, 2) || $past(det_raw.load_request, 3)
        || $past(det_raw.load_request, 4)) else $error("on timer started without request");
    AST_EV2_B: assert property (mode == MODE_EVENT2 && busy.on_busy_flag
        && $past(busy.on_busy_flag) |-> b_on) else $error("output b open while on timer runs");
    AST_TMR_START: assert property (mode == MODE_TIMER && $rose(busy.on_busy_flag)
        |-> $rose(busy.guard_busy_flag)) else $error("on and guard did not start together");
    AST_REST_CAUSE: assert property ($rose(busy.rest_busy_flag) |->
        $past(busy.on_busy_flag, 1) || $past(busy.on_busy_flag, 2)
        || $past(busy.on_busy_flag, 3)) else $error("rest timer started without on timer end");
    AST_TMR_A_REST: assert property (mode == MODE_TIMER && busy.rest_busy_flag
        && $past(busy.rest_busy_flag) |-> !a_on) else $error("output a closed during rest");
    AST_TMR_B_OPEN: assert property (mode == MODE_TIMER && (busy[2] || busy[0])
        && $past(busy[2] || busy[0]) |-> !b_on) else $error("output b closed in guard or rest");

    cover property (mode == MODE_TIMER && busy.rest_busy_flag);
    cover property (mode == MODE_EVENT2 && busy.on_busy_flag && b_on);
    cover property (apb_rsp.pready && apb_rsp.pslverr);
endmodule : gating_chk

bind load_power_gating_control gating_chk chk_u (.pclk(pclk), .presetn(presetn),
    .apb_req(apb_req), .apb_rsp(apb_rsp), .det_raw(det_raw), .sw(sw), .busy(busy), .mode(mode));

// *** bench/sensor_load.sv ***
`timescale 1ns/100ps
module sensor_load (
    // clock and reset
    input  wire logic pclk,
    input  wire logic presetn,
    // command
    input  wire logic want,
    input  wire logic slow,
    // request line
    output logic      load_request
);
    logic [2:0] lag_q;
    // slow load answers three cycles late
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lag_q        <= 3'h0;
            load_request <= 1'b0;
        end else begin
            lag_q        <= {lag_q[1:0], want};
            load_request <= slow ? lag_q[2] : want;
        end
    end
endmodule : sensor_load

// *** bench/testbench.sv ***
`timescale 1ns/100ps
module testbench;
    import gating_pkg::*;
    localparam int UP = 9;
    localparam int LO = 8;
    localparam int SD = 7;
    localparam int SU = 6;
    localparam int BD = 5;
    localparam int BU = 4;
    localparam int GB = 2;
    localparam int OB = 1;
    localparam int RB = 0;
    logic        pclk;
    logic        presetn;
    apb_req_s    req;
    apb_rsp_s    rsp;
    det_s        det;
    det_s        det_in;
    sw_s         sw;
    busy_s       busy;
    gate_mode_e  mode;
    logic        want;
    logic        slow;
    logic        req_line;
    int          fails;
    int          checks_done;
    int          seed;
    int          n;
    logic [31:0] rd;
    logic        err;
    logic [15:0] per [3];
    logic [2:0]  straps [4] = '{3'b000, 3'b001, 3'b100, 3'b110};

    load_power_gating_control dut_u (.pclk(pclk), .presetn(presetn), .apb_req(req),
        .apb_rsp(rsp), .det_raw(det_in), .sw(sw), .busy(busy), .mode(mode));
    sensor_load load_u (.pclk(pclk), .presetn(presetn), .want(want), .slow(slow),
        .load_request(req_line));

    always #10 pclk = ~pclk;
    always_comb begin
        det_in = det;
        det_in.load_request = req_line;
    end

    function automatic logic [1:0] mode_of(input logic [2:0] s);
        case (s)
            3'b001:  return 2'b01;
            3'b100:  return 2'b11;
            3'b110:  return 2'b10;
            default: return 2'b00;
        endcase
    endfunction : mode_of

    function automatic logic [3:0] sw_of(input logic a, input logic b, input logic bat);
        return bat ? {2'b00, a, b} : {a, b, 2'b00};
    endfunction : sw_of

    task automatic end_of_test();
        if (fails == 0 && checks_done > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : end_of_test

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge pclk);
        req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
        @(posedge pclk);
        req.penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (rsp.pready !== 1'b1 && k < 50);
        rd = rsp.prdata;
        err = rsp.pslverr;
        req <= '0;
        if (rsp.pready !== 1'b1) begin
            fails++;
            end_of_test();
        end
    endtask : apb

    task automatic pulse(input int i);
        @(posedge pclk);
        det[i] <= 1'b1;
        repeat (4) @(posedge pclk);
        det[i] <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask : pulse

    task automatic wait_busy(input int b, input logic v, output int cnt);
        cnt = 0;
        do begin
            @(posedge pclk);
            cnt++;
        end while (busy[b] !== v && cnt < 3000);
        if (busy[b] !== v) begin
            fails++;
            end_of_test();
        end
    endtask : wait_busy

    task automatic power_up(input logic [2:0] s);
        pulse(SU);
        det[2:0] <= s;
        pulse(SD);
        det[2:0] <= 3'b000;
        repeat (4) @(posedge pclk);
        chk(mode, mode_of(s));
    endtask : power_up

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        req = '0;
        det = '0;
        want = 1'b0;
        slow = 1'b0;
        fails = 0;
        checks_done = 0;
        seed = 35373;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, GUARD_OFS, 32'h0);
        chk(rd, {16'h0, GUARD_RST});
        apb(1'b0, ON_OFS, 32'h0);
        chk(rd, {16'h0, ON_RST});
        apb(1'b0, REST_OFS, 32'h0);
        chk(rd, {16'h0, REST_RST});
        apb(1'b0, 8'h14, 32'h0);
        chk({31'h0, err}, 32'h1);
        chk(rd, 32'h0);
        per[0] = 16'(20 + ($unsigned($random(seed)) % 16));
        per[1] = per[0] + 16'(10 + ($unsigned($random(seed)) % 16));
        per[2] = 16'(16 + ($unsigned($random(seed)) % 32));
        for (int i = 0; i < 3; i++) begin
            apb(1'b1, GUARD_OFS + 8'(4 * i), {16'h0, per[i]});
            apb(1'b0, GUARD_OFS + 8'(4 * i), 32'h0);
            chk(rd, {16'h0, per[i]});
        end
        for (int i = 0; i < 4; i++) power_up(straps[i]);
        // energy mode, both sources
        power_up(3'b000);
        pulse(UP);
        chk(sw, sw_of(1, 1, 0));
        apb(1'b0, STATUS_OFS, 32'h0);
        chk(rd, 32'(3 << ST_SUPPLY_BIT) | 32'(sw_of(1, 1, 0)));
        pulse(LO);
        chk(sw, 0);
        apb(1'b1, CTRL_OFS, 32'h1);
        apb(1'b0, CTRL_OFS, 32'h0);
        chk(rd, 32'h1);
        pulse(BD);
        chk(sw, sw_of(1, 1, 1));
        pulse(BU);
        chk(sw, 0);
        apb(1'b1, CTRL_OFS, 32'h0);
        // event mode 1
        power_up(3'b001);
        pulse(UP);
        chk(busy[GB], 1);
        want <= 1'b1;
        repeat (4) @(posedge pclk);
        chk(sw, sw_of(1, 0, 0));
        wait_busy(GB, 0, n);
        repeat (4) @(posedge pclk);
        chk(sw, sw_of(1, 1, 0));
        want <= 1'b0;
        repeat (6) @(posedge pclk);
        chk(sw, sw_of(1, 0, 0));
        pulse(LO);
        chk(sw, 0);
        // event mode 2, slow requester
        power_up(3'b100);
        pulse(UP);
        slow <= 1'b1;
        want <= 1'b1;
        repeat (8) @(posedge pclk);
        chk(busy, 3'b100);
        want <= 1'b0;
        wait_busy(GB, 0, n);
        want <= 1'b1;
        wait_busy(OB, 1, n);
        want <= 1'b0;
        repeat (3) @(posedge pclk);
        chk(sw, sw_of(1, 1, 0));
        wait_busy(OB, 0, n);
        chk(n + 3, per[1]);
        repeat (3) @(posedge pclk);
        chk(sw, sw_of(1, 0, 0));
        want <= 1'b1;
        wait_busy(OB, 1, n);
        want <= 1'b0;
        pulse(LO);
        chk(busy, 0);
        slow <= 1'b0;
        // timer mode, solar
        power_up(3'b110);
        pulse(UP);
        chk(busy, 3'b110);
        chk(sw, sw_of(1, 0, 0));
        wait_busy(GB, 0, n);
        repeat (3) @(posedge pclk);
        chk(sw, sw_of(1, 1, 0));
        wait_busy(RB, 1, n);
        repeat (2) @(posedge pclk);
        chk(sw, 0);
        wait_busy(RB, 0, n);
        chk(n + 2, per[2]);
        wait_busy(OB, 1, n);
        chk(busy[GB], 1);
        pulse(LO);
        chk(busy, 0);
        pulse(UP);
        wait_busy(RB, 1, n);
        pulse(LO);
        chk(busy, 3'b001);
        pulse(SU);
        chk(busy, 0);
        // timer mode, battery
        apb(1'b1, CTRL_OFS, 32'h1);
        power_up(3'b110);
        pulse(BD);
        wait_busy(OB, 1, n);
        pulse(BU);
        chk(busy, 0);
        end_of_test();
    end
endmodule : testbench
